// >>> src/irqf_pkg.sv
// Purpose: shared constants and types of the interrupt source flag block
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   bit positions refer to the 8-bit register images
package irqf_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned PORT_W = 6;
  localparam int unsigned PC_W   = 13;

  // byte offsets
  localparam logic [ADDR_W-1:0] OFS_IRQ_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OPTION    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PFLAG     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PENABLE   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CHG_MASK  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TIMER     = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ANALOG_SELECT_REG     = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CMP_CFG   = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_PORT      = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h24;

  // irq_control_reg fields
  localparam int unsigned GIE_BIT  = 7;
  localparam int unsigned PERIPH_IRQ_ENABLE_BIT = 6;
  localparam int unsigned TIMER_OVF_ENABLE_BIT = 5;
  localparam int unsigned EDGE_IRQ_ENABLE_BIT = 4;
  localparam int unsigned PORT_CHANGE_ENABLE_BIT = 3;
  localparam int unsigned TIMER_OVF_FLAG_BIT = 2;
  localparam int unsigned EDGE_IRQ_FLAG_BIT = 1;
  localparam int unsigned PORT_CHANGE_FLAG_BIT = 0;
  // option register: edge polarity select
  localparam int unsigned POL_BIT  = 6;
  // periph_flag_reg / periph_enable_reg fields
  localparam int unsigned ADC_BIT  = 6;
  localparam int unsigned CMP_BIT  = 3;
  localparam logic [7:0]  PERIPH_MASK = 8'h48;

  localparam logic [7:0]        RST_BYTE    = 8'h00;
  localparam logic [7:0]        TIMER_MAX   = 8'hff;
  localparam logic [7:0]        TIMER_STEP  = 8'h01;
  localparam logic [PORT_W-1:0] RST_MASK    = 6'h00;
  localparam logic [PORT_W-1:0] RST_ANALOG_SELECT_REG   = 6'h3f;
  localparam logic [PC_W-1:0]   IRQ_VECTOR  = 13'h0004;
  localparam logic [31:0]       RD_ZERO     = 32'h0000_0000;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } irqf_phase_t;

  typedef enum logic [1:0] {
    SQ_IDLE   = 2'b00,
    SQ_DUMMY1 = 2'b01,
    SQ_DUMMY2 = 2'b11,
    SQ_VECTOR = 2'b10
  } irqf_seq_t;

endpackage : irqf_pkg

// >>> src/irqf_change_det.sv
// Purpose: per-bit rise, fall and change detection with registered outputs
// Assumes: inputs synchronous to pclk
// Notes:   one cycle of delay from input change to output pulse
`timescale 1ns/1ps
module irqf_change_det #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] sig_in,
  output logic      [W-1:0] rise_q,
  output logic      [W-1:0] fall_q,
  output logic      [W-1:0] chg_q
);

  logic [W-1:0] prev_q;
  logic [W-1:0] prev_d;
  logic [W-1:0] rise_d;
  logic [W-1:0] fall_d;
  logic [W-1:0] chg_d;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_comb begin
        prev_d[gi] = sig_in[gi];
        rise_d[gi] = sig_in[gi] & ~prev_q[gi];
        fall_d[gi] = ~sig_in[gi] & prev_q[gi];
        chg_d[gi]  = sig_in[gi] ^ prev_q[gi];
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= '0;
      rise_q <= '0;
      fall_q <= '0;
      chg_q  <= '0;
    end else begin
      prev_q <= prev_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      chg_q  <= chg_d;
    end
  end

endmodule : irqf_change_det

// >>> src/irqf_top.sv
// Purpose: interrupt source flags, enables, wake-up and vector sequencer
// Assumes: one pclk is one quarter phase, four make an instruction cycle
// Notes:   apb slave with zero wait states, pready follows setup by one edge
// Overview of operation
// R1: external pin reacts only to rising edge when polarity bit set, falling otherwise.
// R2: a valid pin edge sets the edge interrupt flag, control bit 1.
// R3: edge interrupt requested only while its enable, control bit 4, is set.
// R4: software clears the edge flag in service; hardware holds it until written zero.
// R5: pin edge wakes from sleep if its enable was set before sleep.
// R6: after wake, vector only if global enable set, else continue in sequence.
// R7: timer roll from ff to 00 sets the timer overflow flag, bit 2.
// R8: timer overflow interrupt requested only while enable bit 5 set.
// R9: change on an enabled port pin sets the port change flag, bit 0.
// R10: port change gated by enable bit 3; per-pin mask selects pins.
// R11: pin change coinciding with port read in quarter two may be lost.
// R12: conversion complete sets the conversion flag, peripheral flag bit 6.
// R13: conversion interrupt requested only while peripheral enable bit 6 set.
// R14: sequencer samples the pending flags once per cycle, in quarter one.
// R15: latency three cycles, independent of instruction length.
// R16: edge flag may be set from quarter four through following quarter one.
// R17: analog-configured pins read zero as digital inputs.
// R18: entry clears global enable, two dummy cycles, push return, load vector.
// R19: peripheral requests need source, peripheral and global enables; flags still set.
// R20: comparator flag set on every output change, by software write of one too.
`timescale 1ns/1ps
module irqf_top (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [irqf_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         ext_irq_pin,
  input  wire logic [irqf_pkg::PORT_W-1:0]  port_in,
  input  wire logic                         timer_inc,
  input  wire logic                         conv_done,
  input  wire logic                         comparator_out,
  input  wire logic                         sleep_enter,
  output logic      [1:0]                   quarter_phase,
  output logic                              sleeping,
  output logic                              wake_pulse,
  output logic                              irq_entry,
  output logic                              dummy_cycle,
  output logic                              push_return,
  output logic                              vector_load,
  output logic      [irqf_pkg::PC_W-1:0]    vector_addr
);

  // bus group
  logic                        pready_q, pready_d;
  logic                        pslverr_q, pslverr_d;
  logic [31:0]                 prdata_q, prdata_d;
  logic                        setup;
  logic                        access;
  logic                        wr_ctrl, wr_opt, wr_pflag, wr_pen, wr_mask, wr_tmr, wr_analog_select_reg, wr_cmp;
  logic                        port_rd;
  logic                        hit;
  logic [irqf_pkg::PORT_W-1:0] port_digital;

  // register group
  logic [7:0]                  ctrl_q, ctrl_d;
  logic [7:0]                  opt_q, opt_d;
  logic [7:0]                  pflag_q, pflag_d;
  logic [7:0]                  pen_q, pen_d;
  logic [7:0]                  tmr_q, tmr_d;
  logic [irqf_pkg::PORT_W-1:0] mask_q, mask_d;
  logic [irqf_pkg::PORT_W-1:0] analog_select_reg_q, analog_select_reg_d;
  logic [irqf_pkg::PORT_W-1:0] cmpcfg_q, cmpcfg_d;
  logic                        edge_pend_q, edge_pend_d;
  logic                        tmr_ovf;
  logic                        edge_seen;
  logic                        edge_window;
  logic                        port_set;

  // sequencer group
  irqf_pkg::irqf_phase_t       phase_q, phase_d;
  irqf_pkg::irqf_seq_t         seq_q, seq_d;
  logic                        sleep_q, sleep_d;
  logic                        edge_irq_enable_sleep_q, edge_irq_enable_sleep_d;
  logic                        wake_q, wake_d;
  logic                        entry_q, entry_d;
  logic                        dummy_q, dummy_d;
  logic                        push_q, push_d;
  logic                        vload_q, vload_d;
  logic [irqf_pkg::PC_W-1:0]   vaddr_q;
  logic                        periph_req;
  logic                        irq_req;
  logic                        wake_cond;
  logic                        seq_start;

  logic                        pin_rise, pin_fall;
  logic [irqf_pkg::PORT_W-1:0] port_chg;
  logic                        cmp_chg;

  irqf_change_det #(.W(1)) u_pin_det (
    .pclk    (pclk),
    .presetn (presetn),
    .sig_in  (ext_irq_pin),
    .rise_q  (pin_rise),
    .fall_q  (pin_fall),
    .chg_q   ()
  );

  irqf_change_det #(.W(irqf_pkg::PORT_W)) u_port_det (
    .pclk    (pclk),
    .presetn (presetn),
    .sig_in  (port_in),
    .rise_q  (),
    .fall_q  (),
    .chg_q   (port_chg)
  );

  irqf_change_det #(.W(1)) u_cmp_det (
    .pclk    (pclk),
    .presetn (presetn),
    .sig_in  (comparator_out),
    .rise_q  (),
    .fall_q  (),
    .chg_q   (cmp_chg)
  );

  // apb decode and read mux
  always_comb begin
    setup     = psel & ~penable;
    access    = psel & penable & pready_q;
    wr_ctrl   = 1'b0;
    wr_opt    = 1'b0;
    wr_pflag  = 1'b0;
    wr_pen    = 1'b0;
    wr_mask   = 1'b0;
    wr_tmr    = 1'b0;
    wr_analog_select_reg  = 1'b0;
    wr_cmp    = 1'b0;
    port_rd   = 1'b0;
    hit       = 1'b1;
    prdata_d  = irqf_pkg::RD_ZERO;
    port_digital = port_in & ~(analog_select_reg_q | cmpcfg_q);                            // [R17]
    if (paddr == irqf_pkg::OFS_IRQ_CTRL) begin
      wr_ctrl = access & pwrite;
      prdata_d[7:0] = ctrl_q;
    end else if (paddr == irqf_pkg::OFS_OPTION) begin
      wr_opt = access & pwrite;
      prdata_d[7:0] = opt_q;
    end else if (paddr == irqf_pkg::OFS_PFLAG) begin
      wr_pflag = access & pwrite;
      prdata_d[7:0] = pflag_q;
    end else if (paddr == irqf_pkg::OFS_PENABLE) begin
      wr_pen = access & pwrite;
      prdata_d[7:0] = pen_q;
    end else if (paddr == irqf_pkg::OFS_CHG_MASK) begin
      wr_mask = access & pwrite;
      prdata_d[irqf_pkg::PORT_W-1:0] = mask_q;
    end else if (paddr == irqf_pkg::OFS_TIMER) begin
      wr_tmr = access & pwrite;
      prdata_d[7:0] = tmr_q;
    end else if (paddr == irqf_pkg::OFS_ANALOG_SELECT_REG) begin
      wr_analog_select_reg = access & pwrite;
      prdata_d[irqf_pkg::PORT_W-1:0] = analog_select_reg_q;
    end else if (paddr == irqf_pkg::OFS_CMP_CFG) begin
      wr_cmp = access & pwrite;
      prdata_d[irqf_pkg::PORT_W-1:0] = cmpcfg_q;
    end else if (paddr == irqf_pkg::OFS_PORT) begin
      port_rd = access & ~pwrite;
      prdata_d[irqf_pkg::PORT_W-1:0] = port_digital;
    end else if (paddr == irqf_pkg::OFS_STATUS) begin
      prdata_d[3:0] = {sleep_q, dummy_q, seq_q};
    end else begin
      hit = 1'b0;
    end
    pready_d  = setup;
    pslverr_d = setup & ~hit;
    if (!setup || pwrite) begin
      prdata_d = prdata_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= irqf_pkg::RD_ZERO;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // flags, enables and timer
  always_comb begin
    ctrl_d      = ctrl_q;
    opt_d       = opt_q;
    pflag_d     = pflag_q;
    pen_d       = pen_q;
    tmr_d       = tmr_q;
    mask_d      = mask_q;
    analog_select_reg_d     = analog_select_reg_q;
    cmpcfg_d    = cmpcfg_q;
    edge_seen   = opt_q[irqf_pkg::POL_BIT] ? pin_rise : pin_fall;               // [R1]
    edge_window = (phase_q == irqf_pkg::PH_Q4) | (phase_q == irqf_pkg::PH_Q1);
    edge_pend_d = edge_pend_q | edge_seen;
    tmr_ovf     = timer_inc & (tmr_q == irqf_pkg::TIMER_MAX) & ~wr_tmr;         // [R7]
    port_set    = |(port_chg & mask_q);                                        // [R10]
    if (port_rd && (phase_q == irqf_pkg::PH_Q2)) begin
      port_set = 1'b0;                                                         // [R11]
    end
    if (timer_inc) begin
      tmr_d = tmr_q + irqf_pkg::TIMER_STEP;
    end
    if (wr_tmr)   tmr_d    = pwdata[7:0];
    if (wr_opt)   opt_d    = pwdata[7:0];
    if (wr_pen)   pen_d    = pwdata[7:0] & irqf_pkg::PERIPH_MASK;
    if (wr_mask)  mask_d   = pwdata[irqf_pkg::PORT_W-1:0];
    if (wr_analog_select_reg) analog_select_reg_d  = pwdata[irqf_pkg::PORT_W-1:0];
    if (wr_cmp)   cmpcfg_d = pwdata[irqf_pkg::PORT_W-1:0];
    if (wr_ctrl)  ctrl_d   = pwdata[7:0];                                      // [R4]
    if (wr_pflag) pflag_d  = pwdata[7:0] & irqf_pkg::PERIPH_MASK;              // [R20]
    if (seq_start) begin
      ctrl_d[irqf_pkg::GIE_BIT] = 1'b0;                                        // [R18]
    end
    // hardware sets win over a same-cycle software clear
    if (edge_window && edge_pend_d) begin
      ctrl_d[irqf_pkg::EDGE_IRQ_FLAG_BIT] = 1'b1;                                       // [R2] [R16]
      edge_pend_d = 1'b0;
    end
    if (tmr_ovf)   ctrl_d[irqf_pkg::TIMER_OVF_FLAG_BIT] = 1'b1;                          // [R7]
    if (port_set)  ctrl_d[irqf_pkg::PORT_CHANGE_FLAG_BIT] = 1'b1;                          // [R9]
    if (conv_done) pflag_d[irqf_pkg::ADC_BIT] = 1'b1;                          // [R12]
    if (cmp_chg)   pflag_d[irqf_pkg::CMP_BIT] = 1'b1;                          // [R20]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= irqf_pkg::RST_BYTE;
      opt_q       <= irqf_pkg::RST_BYTE;
      pflag_q     <= irqf_pkg::RST_BYTE;
      pen_q       <= irqf_pkg::RST_BYTE;
      tmr_q       <= irqf_pkg::RST_BYTE;
      mask_q      <= irqf_pkg::RST_MASK;
      analog_select_reg_q     <= irqf_pkg::RST_ANALOG_SELECT_REG;
      cmpcfg_q    <= irqf_pkg::RST_ANALOG_SELECT_REG;
      edge_pend_q <= 1'b0;
    end else begin
      ctrl_q      <= ctrl_d;
      opt_q       <= opt_d;
      pflag_q     <= pflag_d;
      pen_q       <= pen_d;
      tmr_q       <= tmr_d;
      mask_q      <= mask_d;
      analog_select_reg_q     <= analog_select_reg_d;
      cmpcfg_q    <= cmpcfg_d;
      edge_pend_q <= edge_pend_d;
    end
  end

  // quarter phases, sleep and vector sequencer
  always_comb begin
    periph_req = ctrl_q[irqf_pkg::PERIPH_IRQ_ENABLE_BIT] &                                  // [R19]
                 |(pflag_q & pen_q & irqf_pkg::PERIPH_MASK);                   // [R13]
    irq_req    = ctrl_q[irqf_pkg::GIE_BIT] & (periph_req |                     // [R19]
                 (ctrl_q[irqf_pkg::EDGE_IRQ_FLAG_BIT] & ctrl_q[irqf_pkg::EDGE_IRQ_ENABLE_BIT]) |   // [R3]
                 (ctrl_q[irqf_pkg::TIMER_OVF_FLAG_BIT] & ctrl_q[irqf_pkg::TIMER_OVF_ENABLE_BIT]) |   // [R8]
                 (ctrl_q[irqf_pkg::PORT_CHANGE_FLAG_BIT] & ctrl_q[irqf_pkg::PORT_CHANGE_ENABLE_BIT]));   // [R10]
    wake_cond  = (ctrl_q[irqf_pkg::EDGE_IRQ_FLAG_BIT] & edge_irq_enable_sleep_q) |                 // [R5]
                 (ctrl_q[irqf_pkg::TIMER_OVF_FLAG_BIT] & ctrl_q[irqf_pkg::TIMER_OVF_ENABLE_BIT]) |
                 (ctrl_q[irqf_pkg::PORT_CHANGE_FLAG_BIT] & ctrl_q[irqf_pkg::PORT_CHANGE_ENABLE_BIT]) |
                 |(pflag_q & pen_q & irqf_pkg::PERIPH_MASK);
    case (phase_q)
      irqf_pkg::PH_Q1: phase_d = irqf_pkg::PH_Q2;
      irqf_pkg::PH_Q2: phase_d = irqf_pkg::PH_Q3;
      irqf_pkg::PH_Q3: phase_d = irqf_pkg::PH_Q4;
      default:         phase_d = irqf_pkg::PH_Q1;
    endcase
    sleep_d      = sleep_q;
    edge_irq_enable_sleep_d = edge_irq_enable_sleep_q;
    wake_d       = 1'b0;
    if (sleep_enter && !sleep_q) begin
      sleep_d      = 1'b1;
      edge_irq_enable_sleep_d = ctrl_q[irqf_pkg::EDGE_IRQ_ENABLE_BIT];                               // [R5]
    end else if (sleep_q && wake_cond) begin
      sleep_d = 1'b0;
      wake_d  = 1'b1;
    end
    // entry only while awake and global enable set; otherwise execution continues
    seq_start = (phase_q == irqf_pkg::PH_Q1) & (seq_q == irqf_pkg::SQ_IDLE) &  // [R14]
                irq_req & ~sleep_q;                                            // [R6]
    seq_d   = seq_q;
    entry_d = 1'b0;
    push_d  = 1'b0;
    vload_d = 1'b0;
    case (seq_q)
      irqf_pkg::SQ_IDLE: begin
        if (seq_start) begin
          seq_d   = irqf_pkg::SQ_DUMMY1;                                       // [R18]
          entry_d = 1'b1;
        end
      end
      irqf_pkg::SQ_DUMMY1: begin
        if (phase_q == irqf_pkg::PH_Q1) seq_d = irqf_pkg::SQ_DUMMY2;           // [R15]
      end
      irqf_pkg::SQ_DUMMY2: begin
        if (phase_q == irqf_pkg::PH_Q1) begin
          seq_d   = irqf_pkg::SQ_VECTOR;                                       // [R18]
          push_d  = 1'b1;
          vload_d = 1'b1;
        end
      end
      default: begin
        if (phase_q == irqf_pkg::PH_Q1) seq_d = irqf_pkg::SQ_IDLE;
      end
    endcase
    dummy_d = (seq_d == irqf_pkg::SQ_DUMMY1) | (seq_d == irqf_pkg::SQ_DUMMY2);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q      <= irqf_pkg::PH_Q1;
      seq_q        <= irqf_pkg::SQ_IDLE;
      sleep_q      <= 1'b0;
      edge_irq_enable_sleep_q <= 1'b0;
      wake_q       <= 1'b0;
      entry_q      <= 1'b0;
      dummy_q      <= 1'b0;
      push_q       <= 1'b0;
      vload_q      <= 1'b0;
      vaddr_q      <= irqf_pkg::IRQ_VECTOR;
    end else begin
      phase_q      <= phase_d;
      seq_q        <= seq_d;
      sleep_q      <= sleep_d;
      edge_irq_enable_sleep_q <= edge_irq_enable_sleep_d;
      wake_q       <= wake_d;
      entry_q      <= entry_d;
      dummy_q      <= dummy_d;
      push_q       <= push_d;
      vload_q      <= vload_d;
      vaddr_q      <= irqf_pkg::IRQ_VECTOR;
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign quarter_phase = phase_q;
  assign sleeping      = sleep_q;
  assign wake_pulse    = wake_q;
  assign irq_entry     = entry_q;
  assign dummy_cycle   = dummy_q;
  assign push_return   = push_q;
  assign vector_load   = vload_q;
  assign vector_addr   = vaddr_q;

endmodule : irqf_top

// >>> bench/irqf_checker.sv
// Purpose: concurrent checks on the ports of irqf_top
// Assumes: bound to irqf_top, one clock domain
// Notes:   counts follow the sequencer timing of the block
`timescale 1ns/1ps
module irqf_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  quarter_phase,
  input wire logic        sleeping,
  input wire logic        wake_pulse,
  input wire logic        irq_entry,
  input wire logic        dummy_cycle,
  input wire logic        push_return,
  input wire logic        vector_load,
  input wire logic [12:0] vector_addr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_phase; quarter_phase == 2'b00 |=> quarter_phase == 2'b01; endproperty
  a_phase: assert property (p_phase) else $error("phase did not advance");
  property p_entry_q1; irq_entry |-> $past(quarter_phase) == 2'b00; endproperty
  a_entry_q1: assert property (p_entry_q1) else $error("entry off first phase");
  property p_dummy; irq_entry |=> dummy_cycle [*6]; endproperty
  a_dummy: assert property (p_dummy) else $error("dummy cycles missing");
  property p_lat; irq_entry |-> ##[7:9] vector_load; endproperty
  a_lat: assert property (p_lat) else $error("vector load late");
  property p_push; vector_load == push_return; endproperty
  a_push: assert property (p_push) else $error("push apart from vector");
  property p_vec; vector_addr == 13'h0004; endproperty
  a_vec: assert property (p_vec) else $error("wrong vector");
  property p_wake; wake_pulse |-> $fell(sleeping); endproperty
  a_wake: assert property (p_wake) else $error("wake without leaving sleep");
  property p_quiet; sleeping |-> !irq_entry; endproperty
  a_quiet: assert property (p_quiet) else $error("entry while asleep");
endmodule : irqf_checker

// >>> bench/irqf_far_model.sv
// Purpose: core and pin side model driving pin and sleep request
// Assumes: commands from the bench, applied one edge later
// Notes:   sleep is only requested by an awake core
`timescale 1ns/1ps
module irqf_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_cmd,
  input wire logic sleep_cmd,
  input wire logic sleeping,
  output logic     ext_irq_pin,
  output logic     sleep_enter
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_pin <= 1'b0;
      sleep_enter <= 1'b0;
    end else begin
      ext_irq_pin <= pin_cmd;
      sleep_enter <= sleep_cmd && !sleeping;
    end
  end
endmodule : irqf_far_model

// >>> bench/tb_top.sv
// Purpose: self-checking bench for irqf_top
// Assumes: apb reads scored from a queue of expected words
// Notes:   pin and sleep go through the far side model
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  localparam logic [7:0] CTL = irqf_pkg::OFS_IRQ_CTRL;
  localparam logic [7:0] OPT = irqf_pkg::OFS_OPTION;
  localparam logic [7:0] PFL = irqf_pkg::OFS_PFLAG;
  localparam logic [7:0] PEN = irqf_pkg::OFS_PENABLE;
  localparam logic [7:0] TMR = irqf_pkg::OFS_TIMER;
  localparam logic [7:0] STA = irqf_pkg::OFS_STATUS;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0]  port_in;
  logic [1:0]  phase;
  logic        pin_cmd, sleep_cmd, timer_inc, conv_done, cmp_out;
  logic        ext_irq_pin, sleep_enter, sleeping, wake_pulse, irq_entry, vector_load;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [23:0] tbl[9] = '{24'h820000, 24'h920001, 24'h840000, 24'ha40001, 24'h810000,
                          24'h890001, 24'hc00000, 24'h804000, 24'hc04001};
  int          fail_count, n_compared, n_entry, n_wake, cyc, ent, wk, seed;
  irqf_top irqf_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_irq_pin, .port_in, .timer_inc, .conv_done, .comparator_out(cmp_out),
    .sleep_enter, .quarter_phase(phase), .sleeping, .wake_pulse, .irq_entry, .dummy_cycle(),
    .push_return(), .vector_load, .vector_addr());
  irqf_far_model irqf_far_model_inst (.pclk, .presetn, .pin_cmd, .sleep_cmd, .sleeping,
    .ext_irq_pin, .sleep_enter);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (irq_entry === 1'b1) n_entry++;
    if (wake_pulse === 1'b1) n_wake++;
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      `CHK({pslverr, prdata}, e)
    end
    if (cyc == 30000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic err = 1'b0);
    exp_q.push_back({err, 24'h0, x});
    apb(1'b0, a, 8'h00);
  endtask : rd
  task automatic pulse_conv();
    conv_done <= 1'b1;
    @(posedge pclk);
    conv_done <= 1'b0;
  endtask : pulse_conv
  task summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  initial begin
    seed = 32'h8ddd;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {port_in, pin_cmd, sleep_cmd, timer_inc, conv_done, cmp_out} = '0;
    tick(12);
    presetn <= 1'b1;
    rd(CTL, 8'h00);
    rd(irqf_pkg::OFS_ANALOG_SELECT_REG, 8'h3f);
    port_in <= 6'($random(seed)) | 6'h30;
    rd(irqf_pkg::OFS_PORT, 8'h00);
    rd(8'h40, 8'h00, 1'b1);
    wr(irqf_pkg::OFS_ANALOG_SELECT_REG, 8'h0f);
    wr(irqf_pkg::OFS_CMP_CFG, 8'h00);
    rd(irqf_pkg::OFS_PORT, {2'b0, port_in & 6'h30});
    $display("test registers done");
    for (int p = 0; p < 2; p++) begin
      pin_cmd <= p[0];
      wr(OPT, {1'b0, p[0], 6'h0});
      wr(CTL, 8'h00);
      pin_cmd <= !p[0];
      tick(6);
      rd(CTL, 8'h00);
      pin_cmd <= p[0];
      tick(6);
      rd(CTL, 8'h02);
      tick(20);
      rd(CTL, 8'h02);
      wr(CTL, 8'h00);
    end
    $display("test edge done");
    for (int i = 0; i < 2; i++) begin
      wr(CTL, 8'h00);
      wr(TMR, 8'(8'hfe + i));
      timer_inc <= 1'b1;
      @(posedge pclk);
      timer_inc <= 1'b0;
      rd(TMR, 8'(8'hff + i));
      rd(CTL, i ? 8'h04 : 8'h00);
    end
    wr(irqf_pkg::OFS_CHG_MASK, 8'h01);
    wr(CTL, 8'h00);
    port_in <= port_in ^ 6'h02;
    tick(4);
    rd(CTL, 8'h00);
    port_in <= port_in ^ 6'h01;
    tick(4);
    rd(CTL, 8'h01);
    wr(CTL, 8'h00);
    // align so the port read access cycle falls in quarter two
    do @(posedge pclk); while (phase !== 2'b11);
    fork
      rd(irqf_pkg::OFS_PORT, {2'b0, port_in & 6'h30});
      begin
        @(posedge pclk);
        port_in <= port_in ^ 6'h01;
      end
    join
    tick(4);
    rd(CTL, 8'h00);
    wr(PFL, 8'h00);
    pulse_conv();
    rd(PFL, 8'h40);
    cmp_out <= 1'b1;
    tick(4);
    rd(PFL, 8'h48);
    wr(PFL, 8'h00);
    wr(PFL, 8'h08);
    rd(PFL, 8'h08);
    $display("test flags done");
    wr(PFL, 8'h40);
    foreach (tbl[i]) begin
      wr(CTL, 8'h00);
      wr(PEN, tbl[i][15:8]);
      ent = n_entry;
      wr(CTL, tbl[i][23:16]);
      tick(24);
      `CHK(n_entry - ent, int'(tbl[i][0]))
      rd(CTL, tbl[i][0] ? tbl[i][23:16] & 8'h7f : tbl[i][23:16]);
    end
    $display("test sequencer done");
    wr(PFL, 8'h00);
    wr(PEN, 8'h00);
    pin_cmd <= 1'b0;
    wr(OPT, 8'h40);
    for (int g = 0; g < 3; g++) begin
      wr(CTL, g == 0 ? 8'h00 : (g == 1 ? 8'h10 : 8'h90));
      ent = n_entry;
      wk  = n_wake;
      sleep_cmd <= 1'b1;
      @(posedge pclk);
      sleep_cmd <= 1'b0;
      tick(2);
      rd(STA, 8'h08);
      pin_cmd <= 1'b1;
      tick(24);
      `CHK(n_wake - wk, (g > 0) ? 1 : 0)
      `CHK(n_entry - ent, (g == 2) ? 1 : 0)
      if (g == 0) begin
        wr(PEN, 8'h40);
        pulse_conv();
        tick(8);
        rd(STA, 8'h00);
        wr(PEN, 8'h00);
        wr(PFL, 8'h00);
      end
      pin_cmd <= 1'b0;
      tick(8);
    end
    $display("test sleep done");
    summarize();
  end
endmodule : tb_top
bind irqf_top irqf_checker irqf_checker_inst (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .quarter_phase, .sleeping, .wake_pulse, .irq_entry, .dummy_cycle, .push_return, .vector_load,
  .vector_addr);
